// [verilog/gpe_pkg.sv]
// package: offsets, field positions, reset values and carriers for the general event enable block
package gpe_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] general_event_enable_offset = 8'h2C;
  localparam logic [7:0] general_event_status_offset = 8'h28;
  localparam logic [31:0] general_event_enable_reset = 32'h0000_0000;

  // ---------------------------------------------------------------
  // bit positions
  // ---------------------------------------------------------------
  localparam int thermal_event_enable_bit = 0;
  localparam int thermal_pin_polarity_bit = 2;
  localparam int host1_wake_enable_bit = 3;
  localparam int host2_wake_enable_bit = 4;
  localparam int codec_link_wake_enable_bit = 5;
  localparam int health_logic_sci_enable_bit = 6;
  localparam int ring_wake_enable_bit = 8;
  localparam int pci_wake_enable_bit = 11;
  localparam int host3_wake_enable_bit = 12;
  localparam int internal_bus_wake_enable_bit = 13;
  localparam int host4_wake_enable_bit = 14;
  localparam int input_event_lsb = 16;
  localparam int input_event_count = 16;

  // ---------------------------------------------------------------
  // bit groups
  // ---------------------------------------------------------------
  localparam logic [31:0] implemented_mask = 32'hFFFF_797D;
  localparam logic [31:0] resume_well_mask = 32'hFFFF_10FF;
  localparam logic [31:0] rtc_well_mask = 32'h0000_EF00;
  // status bits whose enable routes to an sci
  localparam logic [31:0] sci_source_mask = 32'hFFFF_2841;
  // status bits whose enable routes to a wake
  localparam logic [31:0] wake_source_mask = 32'hFFFF_7938;
  // status bits whose enable routes to a system management interrupt
  localparam logic [31:0] smi_source_mask = 32'h0000_2001;

  // ---------------------------------------------------------------
  // sleep kinds
  // ---------------------------------------------------------------
  localparam logic [2:0] sleep_kind_soft_off = 3'h5;

  // io read and write carrier
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] data;
  } io_req_s;

  // raw event sources
  typedef struct packed {
    logic [15:0] input_event;
    logic host4_wake;
    logic internal_bus_wake;
    logic host3_wake;
    logic pci_wake;
    logic ring_wake;
    logic health_logic_sci;
    logic codec_link_wake;
    logic host2_wake;
    logic host1_wake;
  } event_src_s;

endpackage

// [verilog/gpe_status.sv]
// sticky event status register, written one to clear
`timescale 1ns/1ps
module gpe_status (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [31:0] set_i,
  input wire logic [31:0] clear_i,
  output logic [31:0] status_o
);

  // ---------------------------------------------------------------
  // sticky bits
  // ---------------------------------------------------------------
  // a set arriving with its clear wins so no event is lost
  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_bit
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          status_o[g] <= 1'b0;
        end else if (set_i[g]) begin
          status_o[g] <= 1'b1;
        end else if (clear_i[g]) begin
          status_o[g] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

// [verilog/general_event_enable_gating.sv]
// general event enable register with status pairing and wake / sci / smi gating
`timescale 1ns/1ps
// How it works
// - each enable bit gates only the status bit at its own position.
// - power button override or thermal trip clears every enable bit.
// - resume reset clears resume-well bits; rtc reset clears rtc-well bits.
// - bits 31..16 let input event status raise sci and wake; resume reset clears.
// - bit 14 lets host 4 wake status raise a wake.
// - bit 12 lets host 3 wake status raise a wake.
// - bit 13 lets internal bus status raise wake, sci or smi; default zero.
// - internal bus wakes from sleep one..four, soft-off unless override entered it.
// - bit 13 cleared by software, rtc reset, override or trip, not hard reset.
// - bit 11 lets pci wake raise sci, and a wake unless override entered soft-off.
// - bit 8 lets ring status wake; survives mechanical-off and hard reset.
// - bit 6 lets health logic status raise an sci.
// - bit 5 lets codec link status raise a wake.
// - bits 4 and 3 let hosts 2 and 1 raise a wake.
// - bit 2 picks which thermal pin level sets thermal status.
// - bit 0 lets thermal status, set by the active pin whatever bit 0 holds, raise sci and smi.
module general_event_enable_gating (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic resume_well_resetn_i,
  input wire logic rtc_well_resetn_i,
  input wire logic hard_resetn_i,
  input wire gpe_pkg::io_req_s io_req_i,
  output logic [31:0] io_rdata_o,
  input wire gpe_pkg::event_src_s event_src_i,
  input wire logic thermal_pin_i,
  input wire logic button_override_i,
  input wire logic thermal_trip_i,
  input wire logic [2:0] sleep_kind_i,
  input wire logic sleeping_i,
  input wire logic off_by_override_i,
  output logic [31:0] general_event_enable_o,
  output logic wake_request_o,
  output logic sci_request_o,
  output logic smi_request_o
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] thermal_sync;
  logic [1:0] override_sync;
  logic [1:0] trip_sync;

  // the first stage only feeds the second
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      // the pin idles high; a low reset value would pose as an asserted pin for two cycles
      thermal_sync <= 2'h3;
      override_sync <= 2'h0;
      trip_sync <= 2'h0;
    end else begin
      thermal_sync <= {thermal_sync[0], thermal_pin_i};
      override_sync <= {override_sync[0], button_override_i};
      trip_sync <= {trip_sync[0], thermal_trip_i};
    end
  end

  logic thermal_level;
  logic clear_all;
  assign thermal_level = thermal_sync[1];
  assign clear_all = override_sync[1] | trip_sync[1];

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
    hit = (addr == offset);
  endfunction

  logic enable_write;
  logic status_write;
  assign enable_write = io_req_i.wr & hit(io_req_i.addr, gpe_pkg::general_event_enable_offset);
  assign status_write = io_req_i.wr & hit(io_req_i.addr, gpe_pkg::general_event_status_offset);

  // ---------------------------------------------------------------
  // enable register, two power wells
  // ---------------------------------------------------------------
  logic [31:0] resume_bits;
  logic [31:0] rtc_bits;
  logic [31:0] write_value;
  // reserved positions never store
  assign write_value = io_req_i.data & gpe_pkg::implemented_mask;

  // resume well; a hard reset also reaches these bits
  always_ff @(posedge clk_i or negedge resume_well_resetn_i) begin
    if (!resume_well_resetn_i) begin
      resume_bits <= gpe_pkg::general_event_enable_reset;
    end else if (clear_all) begin
      resume_bits <= gpe_pkg::general_event_enable_reset;
    end else if (!hard_resetn_i) begin
      resume_bits <= gpe_pkg::general_event_enable_reset;
    end else if (enable_write) begin
      resume_bits <= write_value & gpe_pkg::resume_well_mask;
    end
  end

  // rtc well; a hard reset from the reset control port leaves it alone
  always_ff @(posedge clk_i or negedge rtc_well_resetn_i) begin
    if (!rtc_well_resetn_i) begin
      rtc_bits <= gpe_pkg::general_event_enable_reset;
    end else if (clear_all) begin
      rtc_bits <= gpe_pkg::general_event_enable_reset;
    end else if (enable_write) begin
      rtc_bits <= write_value & gpe_pkg::rtc_well_mask;
    end
  end

  logic [31:0] enable;
  assign enable = resume_bits | rtc_bits;
  assign general_event_enable_o = enable;

  // ---------------------------------------------------------------
  // status capture
  // ---------------------------------------------------------------
  logic thermal_active;
  logic [31:0] status_set;
  logic [31:0] status;
  // polarity bit chooses the level that counts as asserted
  assign thermal_active = enable[gpe_pkg::thermal_pin_polarity_bit] ? thermal_level : ~thermal_level;

  always_comb begin
    status_set = 32'h0000_0000;
    status_set[gpe_pkg::thermal_event_enable_bit] = thermal_active;
    status_set[gpe_pkg::host1_wake_enable_bit] = event_src_i.host1_wake;
    status_set[gpe_pkg::host2_wake_enable_bit] = event_src_i.host2_wake;
    status_set[gpe_pkg::codec_link_wake_enable_bit] = event_src_i.codec_link_wake;
    status_set[gpe_pkg::health_logic_sci_enable_bit] = event_src_i.health_logic_sci;
    status_set[gpe_pkg::ring_wake_enable_bit] = event_src_i.ring_wake;
    status_set[gpe_pkg::pci_wake_enable_bit] = event_src_i.pci_wake;
    status_set[gpe_pkg::host3_wake_enable_bit] = event_src_i.host3_wake;
    status_set[gpe_pkg::internal_bus_wake_enable_bit] = event_src_i.internal_bus_wake;
    status_set[gpe_pkg::host4_wake_enable_bit] = event_src_i.host4_wake;
    status_set[31:16] = event_src_i.input_event;
  end

  gpe_status u_status (
    .clk_i(clk_i),
    .resetn_i(resume_well_resetn_i),
    .set_i(status_set),
    .clear_i(status_write ? (io_req_i.data & gpe_pkg::implemented_mask) : 32'h0000_0000),
    .status_o(status)
  );

  // ---------------------------------------------------------------
  // gating
  // ---------------------------------------------------------------
  logic [31:0] armed;
  logic soft_off;
  logic wake_allowed;
  logic [31:0] wake_gate;
  // each enable only meets its own status bit
  assign armed = status & enable;

  // soft-off entered by button override may not be woken from these sources
  assign soft_off = (sleep_kind_i == gpe_pkg::sleep_kind_soft_off);
  assign wake_allowed = !(sleeping_i && soft_off && off_by_override_i);

  always_comb begin
    wake_gate = gpe_pkg::wake_source_mask;
    wake_gate[gpe_pkg::internal_bus_wake_enable_bit] = wake_allowed;
    wake_gate[gpe_pkg::pci_wake_enable_bit] = wake_allowed;
  end

  // requests are registered so they stay glitch free at the pins
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wake_request_o <= 1'b0;
      sci_request_o <= 1'b0;
      smi_request_o <= 1'b0;
    end else begin
      wake_request_o <= |(armed & wake_gate);
      sci_request_o <= |(armed & gpe_pkg::sci_source_mask);
      smi_request_o <= |(armed & gpe_pkg::smi_source_mask);
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      io_rdata_o <= 32'h0000_0000;
    end else if (io_req_i.rd && hit(io_req_i.addr, gpe_pkg::general_event_enable_offset)) begin
      io_rdata_o <= enable & gpe_pkg::implemented_mask;
    end else if (io_req_i.rd && hit(io_req_i.addr, gpe_pkg::general_event_status_offset)) begin
      io_rdata_o <= status;
    end else begin
      io_rdata_o <= 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_reserved_read_zero: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (enable & ~gpe_pkg::implemented_mask) == 32'h0) else $error("reserved enable bit set");

  a_clear_all_enables: assert property (@(posedge clk_i) disable iff (!resetn_i)
    clear_all |=> enable == 32'h0) else $error("enables survived override or trip");

  a_write_stores: assert property (@(posedge clk_i) disable iff (!resetn_i || !hard_resetn_i)
    enable_write && !clear_all |=> enable == $past(write_value)) else $error("enable write lost");

  a_hard_keeps_rtc: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !hard_resetn_i && !clear_all && !enable_write |=> rtc_bits == $past(rtc_bits)) else $error("rtc bit lost");

  a_status_sticky: assert property (@(posedge clk_i) disable iff (!resetn_i || !resume_well_resetn_i)
    status[3] && !status_write |=> status[3]) else $error("status dropped without clear");

  a_thermal_sets: assert property (@(posedge clk_i) disable iff (!resetn_i || !resume_well_resetn_i)
    thermal_active |=> status[0]) else $error("thermal status not set");

  a_wake_follows: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (armed[4] || armed[3]) |=> wake_request_o) else $error("host wake not raised");

  a_sci_follows: assert property (@(posedge clk_i) disable iff (!resetn_i)
    armed[6] |=> sci_request_o) else $error("health sci not raised");

  a_no_override_wake: assert property (@(posedge clk_i) disable iff (!resetn_i)
    sleeping_i && soft_off && off_by_override_i && (armed & gpe_pkg::wake_source_mask
    & ~((32'h1 << gpe_pkg::internal_bus_wake_enable_bit) | (32'h1 << gpe_pkg::pci_wake_enable_bit))) == 32'h0
    |=> !wake_request_o)
    else $error("wake after override");

  // ---------------------------------------------------------------
  // checks: resets, clears and status capture
  // ---------------------------------------------------------------
  a_resume_reset_clears: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !resume_well_resetn_i |-> (general_event_enable_o & gpe_pkg::resume_well_mask) == 32'h0 && status == 32'h0)
    else $error("resume well bits survived their reset");

  a_rtc_reset_clears: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !rtc_well_resetn_i |-> (general_event_enable_o & gpe_pkg::rtc_well_mask) == 32'h0)
    else $error("rtc well bits survived their reset");

  a_override_clears: assert property (@(posedge clk_i) disable iff (!resetn_i)
    override_sync[1] |=> general_event_enable_o == 32'h0)
    else $error("enables survived button override");

  a_trip_clears: assert property (@(posedge clk_i) disable iff (!resetn_i)
    trip_sync[1] |=> general_event_enable_o == 32'h0)
    else $error("enables survived thermal trip");

  a_status_clears: assert property (@(posedge clk_i) disable iff (!resetn_i)
    status_write && io_req_i.data[gpe_pkg::host1_wake_enable_bit] && !status_set[gpe_pkg::host1_wake_enable_bit]
    |=> !status[gpe_pkg::host1_wake_enable_bit])
    else $error("status not cleared by write of one");

  a_host3_status: assert property (@(posedge clk_i) disable iff (!resetn_i || !resume_well_resetn_i)
    event_src_i.host3_wake |=> status[gpe_pkg::host3_wake_enable_bit])
    else $error("host 3 wake status not set");

  a_host4_status: assert property (@(posedge clk_i) disable iff (!resetn_i || !resume_well_resetn_i)
    event_src_i.host4_wake |=> status[gpe_pkg::host4_wake_enable_bit])
    else $error("host 4 wake status not set");

  a_polarity_sets: assert property (@(posedge clk_i) disable iff (!resetn_i || !resume_well_resetn_i)
    enable[gpe_pkg::thermal_pin_polarity_bit] == thermal_level |=> status[gpe_pkg::thermal_event_enable_bit])
    else $error("selected thermal level did not set status");

  // ---------------------------------------------------------------
  // checks: request routing and read back
  // ---------------------------------------------------------------
  a_input_requests: assert property (@(posedge clk_i) disable iff (!resetn_i)
    armed[31:16] != 16'h0 |=> wake_request_o && sci_request_o)
    else $error("input event request missing");

  a_host4_wake: assert property (@(posedge clk_i) disable iff (!resetn_i)
    armed[gpe_pkg::host4_wake_enable_bit] |=> wake_request_o)
    else $error("host 4 wake not raised");

  a_host3_wake: assert property (@(posedge clk_i) disable iff (!resetn_i)
    armed[gpe_pkg::host3_wake_enable_bit] |=> wake_request_o)
    else $error("host 3 wake not raised");

  a_bus_sci_smi: assert property (@(posedge clk_i) disable iff (!resetn_i)
    armed[gpe_pkg::internal_bus_wake_enable_bit] |=> sci_request_o && smi_request_o)
    else $error("internal bus sci or smi missing");

  a_bus_wake_allowed: assert property (@(posedge clk_i) disable iff (!resetn_i)
    armed[gpe_pkg::internal_bus_wake_enable_bit] && !(sleeping_i && soft_off && off_by_override_i) |=> wake_request_o)
    else $error("internal bus wake missing");

  a_pci_wake_sci: assert property (@(posedge clk_i) disable iff (!resetn_i)
    armed[gpe_pkg::pci_wake_enable_bit] && !(sleeping_i && soft_off && off_by_override_i)
    |=> wake_request_o && sci_request_o)
    else $error("pci wake or sci missing");

  a_ring_wake: assert property (@(posedge clk_i) disable iff (!resetn_i)
    armed[gpe_pkg::ring_wake_enable_bit] |=> wake_request_o)
    else $error("ring wake not raised");

  a_codec_wake: assert property (@(posedge clk_i) disable iff (!resetn_i)
    armed[gpe_pkg::codec_link_wake_enable_bit] |=> wake_request_o)
    else $error("codec link wake not raised");

  a_thermal_requests: assert property (@(posedge clk_i) disable iff (!resetn_i)
    armed[gpe_pkg::thermal_event_enable_bit] |=> sci_request_o && smi_request_o)
    else $error("thermal sci or smi missing");

  a_idle_no_request: assert property (@(posedge clk_i) disable iff (!resetn_i)
    armed == 32'h0 |=> !wake_request_o && !sci_request_o && !smi_request_o)
    else $error("request without an armed source");

  a_enable_readback: assert property (@(posedge clk_i) disable iff (!resetn_i)
    io_req_i.rd && hit(io_req_i.addr, gpe_pkg::general_event_enable_offset) |=> io_rdata_o == $past(general_event_enable_o))
    else $error("enable read back differs");

  a_rdata_reserved: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (io_rdata_o & ~gpe_pkg::implemented_mask) == 32'h0)
    else $error("reserved read data bit set");

endmodule

// [testbench/general_event_enable_gating_tb.sv]
// self-checking bench for the general event enable gating block
`timescale 1ns/1ps
module general_event_enable_gating_tb;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic resume_well_resetn_i = 1'b0;
  logic rtc_well_resetn_i = 1'b0;
  logic hard_resetn_i = 1'b1;
  gpe_pkg::io_req_s io_req_i = '0;
  gpe_pkg::event_src_s event_src_i = '0;
  logic thermal_pin_i = 1'b1;
  logic button_override_i = 1'b0;
  logic thermal_trip_i = 1'b0;
  logic [2:0] sleep_kind_i = 3'h0;
  logic sleeping_i = 1'b0;
  logic off_by_override_i = 1'b0;
  logic [31:0] io_rdata_o;
  logic [31:0] general_event_enable_o;
  logic wake_request_o;
  logic sci_request_o;
  logic smi_request_o;
  logic [31:0] rdv;
  int n_mismatch = 0;
  int checks = 0;
  localparam logic [31:0] all_ones = 32'hFFFF_FFFF;
  localparam logic [7:0] en_a = gpe_pkg::general_event_enable_offset;
  localparam logic [7:0] st_a = gpe_pkg::general_event_status_offset;

  general_event_enable_gating dut (.clk_i, .resetn_i, .resume_well_resetn_i, .rtc_well_resetn_i,
    .hard_resetn_i, .io_req_i, .io_rdata_o, .event_src_i, .thermal_pin_i, .button_override_i,
    .thermal_trip_i, .sleep_kind_i, .sleeping_i, .off_by_override_i, .general_event_enable_o,
    .wake_request_o, .sci_request_o, .smi_request_o);

  // ---------------------------------------------------------------
  // clock, helpers
  // ---------------------------------------------------------------
  always #4 clk_i = ~clk_i;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // one-cycle strobes, driven at the falling edge so the rising edge sees them settled
  task automatic io_write(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_i);
    io_req_i = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
    @(negedge clk_i);
    io_req_i = '0;
  endtask

  task automatic io_read(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk_i);
    io_req_i = '{wr: 1'b0, rd: 1'b1, addr: a, data: 32'h0};
    @(negedge clk_i);
    d = io_rdata_o;
    io_req_i = '0;
  endtask

  function automatic gpe_pkg::event_src_s ev_for(input int b);
    gpe_pkg::event_src_s e;
    e = '0;
    case (b)
      3: e.host1_wake = 1'b1;
      4: e.host2_wake = 1'b1;
      5: e.codec_link_wake = 1'b1;
      6: e.health_logic_sci = 1'b1;
      8: e.ring_wake = 1'b1;
      11: e.pci_wake = 1'b1;
      12: e.host3_wake = 1'b1;
      13: e.internal_bus_wake = 1'b1;
      14: e.host4_wake = 1'b1;
      default: e.input_event[b-16] = 1'b1;
    endcase
    return e;
  endfunction

  task automatic pulse_event(input int b);
    @(negedge clk_i);
    event_src_i = ev_for(b);
    @(negedge clk_i);
    event_src_i = '0;
    settle(3);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_and_reserved;
    check(general_event_enable_o, gpe_pkg::general_event_enable_reset);
    io_read(en_a, rdv);
    check(rdv, gpe_pkg::general_event_enable_reset);
    io_write(en_a, all_ones);
    io_read(en_a, rdv);
    check(rdv, gpe_pkg::implemented_mask);
    io_write(en_a, ~gpe_pkg::implemented_mask);
    check(general_event_enable_o, 32'h0000_0000);
  endtask

  // each source: a foreign enable set must not pass it, its own enable must
  task automatic t_sources;
    int srcs[11] = '{3, 4, 5, 6, 8, 11, 12, 13, 14, 16, 31};
    logic [31:0] m;
    foreach (srcs[i]) begin
      m = 32'h1 << srcs[i];
      io_write(en_a, 32'hFFFF_FFFA & ~m);
      io_write(st_a, all_ones);
      pulse_event(srcs[i]);
      check({29'h0, wake_request_o, sci_request_o, smi_request_o}, 32'h0);
      io_write(en_a, m);
      settle(2);
      check({29'h0, wake_request_o, sci_request_o, smi_request_o}, {29'h0,
        |(gpe_pkg::wake_source_mask & m), |(gpe_pkg::sci_source_mask & m),
        |(gpe_pkg::smi_source_mask & m)});
      io_read(st_a, rdv);
      check(rdv, m);
      io_write(st_a, m);
      settle(2);
      check({31'h0, wake_request_o}, 32'h0);
    end
  endtask

  task automatic t_thermal;
    thermal_pin_i = 1'b0;
    io_write(en_a, 32'h0000_0005);
    io_write(st_a, all_ones);
    settle(3);
    check({31'h0, sci_request_o}, 32'h0);
    thermal_pin_i = 1'b1;
    settle(6);
    check({30'h0, sci_request_o, smi_request_o}, 32'h3);
    thermal_pin_i = 1'b0;
    io_write(en_a, 32'h0000_0001);
    io_write(st_a, all_ones);
    settle(4);
    check({30'h0, sci_request_o, smi_request_o}, 32'h3);
    thermal_pin_i = 1'b1;
    settle(3);
    io_write(st_a, all_ones);
    settle(3);
    check({31'h0, sci_request_o}, 32'h0);
  endtask

  // wake held back from soft-off entered by the override, released otherwise
  task automatic t_sleep_block;
    int b;
    for (int k = 0; k < 2; k++) begin
      b = (k == 0) ? 11 : 13;
      io_write(en_a, 32'h1 << b);
      io_write(st_a, all_ones);
      sleeping_i = 1'b1;
      sleep_kind_i = gpe_pkg::sleep_kind_soft_off;
      off_by_override_i = 1'b1;
      pulse_event(b);
      check({31'h0, wake_request_o}, 32'h0);
      off_by_override_i = 1'b0;
      settle(3);
      check({31'h0, wake_request_o}, 32'h1);
      sleeping_i = 1'b0;
      io_write(st_a, all_ones);
    end
  endtask

  // override and trip both wipe the enables and win over a write
  task automatic t_clear_all;
    for (int k = 0; k < 2; k++) begin
      io_write(en_a, all_ones);
      @(negedge clk_i);
      if (k == 0) button_override_i = 1'b1;
      else thermal_trip_i = 1'b1;
      settle(4);
      check(general_event_enable_o, 32'h0);
      io_write(en_a, all_ones);
      check(general_event_enable_o, 32'h0);
      button_override_i = 1'b0;
      thermal_trip_i = 1'b0;
      settle(3);
    end
  endtask

  task automatic t_well_resets;
    logic [31:0] exp[3];
    exp[0] = gpe_pkg::implemented_mask & ~gpe_pkg::resume_well_mask;
    exp[1] = gpe_pkg::implemented_mask & ~gpe_pkg::rtc_well_mask;
    exp[2] = exp[0];
    for (int k = 0; k < 3; k++) begin
      io_write(en_a, all_ones);
      @(negedge clk_i);
      resume_well_resetn_i = (k != 0);
      rtc_well_resetn_i = (k != 1);
      hard_resetn_i = (k != 2);
      settle(2);
      resume_well_resetn_i = 1'b1;
      rtc_well_resetn_i = 1'b1;
      hard_resetn_i = 1'b1;
      settle(2);
      check(general_event_enable_o, exp[k]);
    end
  endtask

  // ---------------------------------------------------------------
  // verdict, main sequence, watchdog
  // ---------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    settle(5);
    resetn_i = 1'b1;
    resume_well_resetn_i = 1'b1;
    rtc_well_resetn_i = 1'b1;
    settle(2);
    t_reset_and_reserved();
    t_sources();
    t_thermal();
    t_sleep_block();
    t_clear_all();
    t_well_resets();
    tally_and_finish();
  end

  // the whole sequence needs well under two thousand cycles
  initial begin
    #(8 * 20000);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
